// File: core/clock_source_select_and_distribution.sv
// Clock source select, start-up timing and per-domain clock enables.
// Assumes source ticks and watchdog ticks are pins from other domains;
// domain clocks are produced as level enables of CLK_SYS, the async timer's as one-cycle pulses.
`timescale 1ns/10ps
module clock_source_select_and_distribution
   import clk_ctrl_pkg::*;
(
   input  wire logic       CLK_SYS,        // System clock 125 MHz
   input  wire logic       RST_N,          // Async reset, active low
   input  wire logic [3:0] SRC_FUSES,      // Source select fuses
   input  wire logic [1:0] STARTUP_FUSES,  // Start-up time fuses
   input  wire logic       SWING_FUSE,     // Swing option fuse, 0 programmed
   input  wire logic       SRC_TICK,       // Selected source edge, async
   input  wire logic       WDOG_TICK,      // Watchdog oscillator edge, async
   input  wire logic       XTAL32_TICK,    // Watch crystal edge, async
   input  wire logic [2:0] SLEEP_MODE,     // Requested sleep mode (sleep_e)
   input  wire logic       SLEEP_REQ,      // Enter sleep mode, level
   input  wire logic       WAKE_EVT,       // Wake event, same clock
   input  wire logic       ASYNC_IRQ,      // Async interrupt level, async
   input  wire logic       TWO_WIRE_HIT,   // Async address match, async
   output logic            CORE_CLK_EN,    // Core clock enable
   output logic            FLASH_CLK_EN,   // Program memory clock enable
   output logic            PERIPH_CLK_EN,  // Peripheral clock enable
   output logic            CONV_CLK_EN,    // Converter clock enable
   output logic            ASYNC_CLK_EN,   // Async timer clock enable
   output logic [2:0]      SRC_SEL,        // Decoded source (src_e)
   output logic            FULL_SWING,     // Amplifier full swing
   output logic            RUNNING,        // Instructions may execute
   output logic            WAKE_OUT        // Async wake to power control
);
   // ****************************************
   // Reset release and input synchronisers
   // ****************************************
   logic [1:0] rst_sync_r;
   logic       rst_n;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) rst_sync_r <= 2'h0;
      else        rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   logic [4:0] s1_r, s2_r, s3_r;
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 5'h0;
         s2_r <= 5'h0;
         s3_r <= 5'h0;
      end else begin
         s1_r <= {TWO_WIRE_HIT, ASYNC_IRQ, XTAL32_TICK, WDOG_TICK, SRC_TICK};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // Rising edges from second and third stages only
   logic src_edge, wd_edge, x32_edge;
   assign src_edge = s2_r[0] & ~s3_r[0];
   assign wd_edge  = s2_r[1] & ~s3_r[1];
   assign x32_edge = s2_r[2] & ~s3_r[2];

   // ****************************************
   // Fuse latch and decode
   // ****************************************
   typedef enum logic [1:0] {ST_LATCH, ST_RST_DLY, ST_RUN, ST_WAKE} st_e;
   st_e         st_r, st_nxt;
   logic [3:0]  src_f_r, src_f_nxt;
   logic [1:0]  startup_r, startup_nxt;
   logic        swing_r, swing_nxt;
   logic [16:0] cnt_r, cnt_nxt;
   logic        asleep_r, asleep_nxt;
   logic [2:0]  mode_r, mode_nxt;
   src_e        src;
   logic [16:0] rst_dly, wake_dly;

   always_comb begin
      // Ones are unprogrammed, zeros programmed
      if (src_f_r >= 4'ha)       src = SRC_CRYSTAL;   // R8 R9
      else if (src_f_r == 4'h9)  src = SRC_LOWFREQ;
      else if (src_f_r >= 4'h5)  src = SRC_EXT_RC;
      else if (src_f_r >= 4'h1)  src = SRC_INT_RC;
      else                       src = SRC_EXT_CLK;
   end

   always_comb begin
      wake_dly = 17'(SU_6);
      rst_dly  = 17'h0;
      unique case (src)
         SRC_CRYSTAL: begin  // R15
            unique case ({src_f_r[0], startup_r})
               3'h0, 3'h1:  wake_dly = 17'(SU_258);
               3'h2, 3'h3, 3'h4: wake_dly = 17'(SU_1K);
               default:     wake_dly = 17'(SU_16K);
            endcase
            unique case ({src_f_r[0], startup_r})
               3'h0, 3'h3, 3'h6: rst_dly = 17'(WD_SHORT_CYC);
               3'h1, 3'h4, 3'h7: rst_dly = 17'(WD_LONG_CYC);
               default:          rst_dly = 17'h0;
            endcase
         end
         SRC_LOWFREQ: begin
            wake_dly = (startup_r == 2'h2) ? 17'(SU_32K) : 17'(SU_1K);
            rst_dly  = (startup_r == 2'h0) ? 17'(WD_SHORT_CYC) : 17'(WD_LONG_CYC);
         end
         SRC_EXT_RC: begin  // R16
            wake_dly = (startup_r == 2'h3) ? 17'(SU_6) : 17'(SU_18);
            unique case (startup_r)
               2'h0:    rst_dly = 17'h0;
               2'h2:    rst_dly = 17'(WD_LONG_CYC);
               default: rst_dly = 17'(WD_SHORT_CYC);
            endcase
         end
         SRC_INT_RC: begin
            wake_dly = 17'(SU_INT);
            rst_dly  = startup_r[1] ? 17'(WD_LONG_CYC) : 17'(WD_SHORT_CYC);
         end
         SRC_EXT_CLK: begin
            wake_dly = 17'(SU_EXT);
            rst_dly  = startup_r[1] ? 17'(WD_LONG_CYC) : 17'(WD_SHORT_CYC);
         end
      endcase
   end

   // ****************************************
   // Start-up sequencer and sleep state
   // ****************************************
   logic deep;
   assign deep = (mode_r == 3'(SLP_PWR_DOWN)) || (mode_r == 3'(SLP_PWR_SAVE))
              || (mode_r == 3'(SLP_STANDBY));

   always_comb begin
      st_nxt     = st_r;
      src_f_nxt  = src_f_r;
      startup_nxt = startup_r;
      swing_nxt  = swing_r;
      cnt_nxt    = cnt_r;
      asleep_nxt = asleep_r;
      mode_nxt   = mode_r;
      unique case (st_r)
         ST_LATCH: begin
            // Fuses sampled once after reset release, then frozen
            src_f_nxt = SRC_FUSES;  // R17
            startup_nxt = STARTUP_FUSES;
            swing_nxt = SWING_FUSE;
            cnt_nxt   = 17'h0;
            st_nxt    = ST_RST_DLY;
         end
         ST_RST_DLY: begin  // R11
            if (cnt_r >= rst_dly) begin
               st_nxt  = ST_RUN;
               cnt_nxt = 17'h0;
            end else if (wd_edge) begin
               cnt_nxt = cnt_r + 17'h1;
            end
         end
         ST_RUN: begin
            if (!asleep_r && SLEEP_REQ) begin
               asleep_nxt = 1'b1;
               mode_nxt   = SLEEP_MODE;
            end else if (asleep_r && (WAKE_EVT || s2_r[3] || s2_r[4])) begin
               asleep_nxt = 1'b0;
               mode_nxt   = 3'(SLP_ACTIVE);
               // Only deep modes stopped the oscillator
               if (deep) begin  // R10
                  st_nxt  = ST_WAKE;
                  cnt_nxt = 17'h0;
               end
            end
         end
         ST_WAKE: begin  // R10
            if (cnt_r >= wake_dly) st_nxt = ST_RUN;
            else if (src_edge)     cnt_nxt = cnt_r + 17'h1;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         st_r     <= ST_LATCH;
         src_f_r  <= SRC_DEFAULT;  // R12
         startup_r <= STARTUP_DEFAULT;
         swing_r  <= 1'b1;
         cnt_r    <= 17'h0;
         asleep_r <= 1'b0;
         mode_r   <= 3'(SLP_ACTIVE);
      end else begin
         st_r     <= st_nxt;
         src_f_r  <= src_f_nxt;
         startup_r <= startup_nxt;
         swing_r  <= swing_nxt;
         cnt_r    <= cnt_nxt;
         asleep_r <= asleep_nxt;
         mode_r   <= mode_nxt;
      end
   end

   // ****************************************
   // Domain clock enables
   // ****************************************
   clk_en_s en_nxt, en_r;
   logic    run;
   always_comb begin
      run = (st_r == ST_RUN);
      en_nxt.core      = run && !asleep_r;                           // R1 R7
      en_nxt.flash     = en_nxt.core;                                // R4
      en_nxt.periph    = run && (!asleep_r || mode_r == 3'(SLP_IDLE)); // R2
      en_nxt.conv      = run && (!asleep_r || mode_r == 3'(SLP_IDLE)
                         || mode_r == 3'(SLP_ADC_NR));              // R6
      en_nxt.async_tmr = x32_edge;                                   // R5
   end
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) en_r <= '0;
      else        en_r <= en_nxt;
   end
   assign CORE_CLK_EN   = en_r.core;
   assign FLASH_CLK_EN  = en_r.flash;
   assign PERIPH_CLK_EN = en_r.periph;
   assign CONV_CLK_EN   = en_r.conv;
   assign ASYNC_CLK_EN  = en_r.async_tmr;
   assign SRC_SEL       = src;
   assign FULL_SWING    = ~swing_r;  // R13
   assign RUNNING       = run;
   // Async sources still wake while the peripheral clock is off
   assign WAKE_OUT      = asleep_r & (s2_r[3] | s2_r[4]);  // R2 R3
endmodule : clock_source_select_and_distribution

// File: pkg/clk_ctrl_pkg.sv
// Constants and types for the clock source select and distribution block.
// Assumes a single system clock; fuse values arrive as static pins.
// How it works
// R1: Core clock enable feeds core state.
// R2: Peripheral enable; async interrupts bypass it.
// R3: Two-wire address match passes while halted.
// R4: Program memory clock follows core clock.
// R5: Async timer runs from watch crystal always.
// R6: Converter clock runs in noise-reduction sleep.
// R7: Sleep mode gates unused clock domains.
// R8: Decode four-bit source select fuse field.
// R9: Fuse bit one is unprogrammed.
// R10: Wake start-up counted on selected source.
// R11: Reset delay 0, 4096 or 65536 watchdog cycles.
// R12: Delivered defaults 0001 and 10.
// R13: Swing fuse picks amplifier mode.
// R14: Resonator at most 8 or 16 MHz.
// R15: Crystal start-up 258, 1K or 16K.
// R16: External RC start-up 18 or 6.
// R17: Fuses latched at reset only.
package clk_ctrl_pkg;
   localparam logic [3:0] SRC_DEFAULT   = 4'h1;  // R12
   localparam logic [1:0] STARTUP_DEFAULT = 2'h2;  // R12
   localparam int unsigned WD_SHORT_CYC = 4096;  // R11
   localparam int unsigned WD_LONG_CYC  = 65536;
   localparam int unsigned SU_258       = 258;
   localparam int unsigned SU_1K        = 1024;
   localparam int unsigned SU_16K       = 16384;
   localparam int unsigned SU_32K       = 32768;
   localparam int unsigned SU_18        = 18;
   localparam int unsigned SU_6         = 6;
   localparam int unsigned SU_EXT       = 6;
   localparam int unsigned SU_INT       = 6;

   typedef enum logic [2:0] {
      SRC_CRYSTAL, SRC_LOWFREQ, SRC_EXT_RC, SRC_INT_RC, SRC_EXT_CLK
   } src_e;

   typedef enum logic [2:0] {
      SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR, SLP_PWR_DOWN, SLP_PWR_SAVE, SLP_STANDBY
   } sleep_e;

   typedef struct packed {
      logic core;
      logic flash;
      logic periph;
      logic conv;
      logic async_tmr;
   } clk_en_s;
endpackage : clk_ctrl_pkg

// File: tb/osc_model.sv
// Far-side oscillators: selected source, watchdog and watch crystal.
// Assumes free-running sources with periods scaled down for simulation.
`timescale 1ns/10ps
module osc_model #(
   parameter time SRC_HALF  = 32ns,  // 15.6 MHz source
   parameter time WDOG_HALF = 32ns,  // Scaled watchdog oscillator
   parameter time XTAL_HALF = 80ns   // Scaled watch crystal
)(
   output logic src_tick,   // Selected source
   output logic wdog_tick,  // Watchdog oscillator
   output logic xtal_tick   // Watch crystal
);
   initial src_tick = 1'b0;
   initial wdog_tick = 1'b0;
   initial xtal_tick = 1'b0;
   // Resonator kept below the programmed-swing ceiling
   always #SRC_HALF src_tick = ~src_tick;
   always #WDOG_HALF wdog_tick = ~wdog_tick;
   always #XTAL_HALF xtal_tick = ~xtal_tick;
endmodule : osc_model

// File: tb/clk_ctrl_assertions.sv
// Port checks for the clock control block.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/10ps
module clk_ctrl_checker (
   input wire logic       CLK_SYS,        // System clock
   input wire logic       RST_N,          // Reset, active low
   input wire logic       XTAL32_TICK,    // Watch crystal
   input wire logic       CORE_CLK_EN,    // Core enable
   input wire logic       FLASH_CLK_EN,   // Program memory enable
   input wire logic       PERIPH_CLK_EN,  // Peripheral enable
   input wire logic       CONV_CLK_EN,    // Converter enable
   input wire logic       ASYNC_CLK_EN,   // Async timer pulse
   input wire logic [2:0] SRC_SEL,        // Decoded source
   input wire logic       FULL_SWING,     // Amplifier mode
   input wire logic       RUNNING         // Executing
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   a_flash_tracks_core: assert property (FLASH_CLK_EN == CORE_CLK_EN)
      else $error("program memory enable differs from core enable");
   a_core_after_run: assert property ($rose(CORE_CLK_EN) |-> $past(RUNNING))
      else $error("core enable rose without running state");
   a_core_off_halted: assert property ((!RUNNING ##1 !RUNNING) |-> !CORE_CLK_EN)
      else $error("core enable high while halted");
   a_periph_needs_conv: assert property (PERIPH_CLK_EN |-> CONV_CLK_EN)
      else $error("peripheral enable without converter enable");
   a_core_needs_periph: assert property (CORE_CLK_EN |-> PERIPH_CLK_EN)
      else $error("core enable without peripheral enable");
   a_source_held: assert property (RUNNING && $past(RUNNING) |-> $stable(SRC_SEL))
      else $error("source selection changed while running");
   a_swing_held: assert property (RUNNING && $past(RUNNING) |-> $stable(FULL_SWING))
      else $error("swing mode changed while running");
   a_source_legal: assert property (SRC_SEL <= 3'h4)
      else $error("source selection out of range");
   a_async_single: assert property (ASYNC_CLK_EN |=> !ASYNC_CLK_EN)
      else $error("async timer pulse longer than one cycle");
   a_async_follows: assert property ($rose(XTAL32_TICK) && RUNNING |-> ##[1:6] ASYNC_CLK_EN)
      else $error("watch crystal edge gave no async pulse");
endmodule : clk_ctrl_checker
bind clock_source_select_and_distribution clk_ctrl_checker i_chk (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .XTAL32_TICK(XTAL32_TICK), .CORE_CLK_EN(CORE_CLK_EN),
   .FLASH_CLK_EN(FLASH_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .CONV_CLK_EN(CONV_CLK_EN),
   .ASYNC_CLK_EN(ASYNC_CLK_EN), .SRC_SEL(SRC_SEL), .FULL_SWING(FULL_SWING),
   .RUNNING(RUNNING));

// File: tb/clock_source_select_and_distribution_bench.sv
// Self-checking bench for the clock control block.
// Assumes osc_model as the far side; inputs change at falling edges.
`timescale 1ns/10ps
module clock_source_select_and_distribution_bench;
   import clk_ctrl_pkg::*;
   logic       clk_sys = 1'b0, rst_n = 1'b0, swing = 1'b1, sreq = 1'b0, wake = 1'b0;
   logic       irq = 1'b0, hit = 1'b0, src_t, wd_t, x_t, core, flash, per, conv, asy, fsw, run;
   logic [3:0] src_f = 4'h1;
   logic [1:0] startup_f = 2'h2;
   logic       wo;
   logic [2:0] mode = 3'h0, sel;
   int         miscompares = 0, samples_checked = 0;
   always #4 clk_sys = ~clk_sys;
   osc_model i_osc (.src_tick(src_t), .wdog_tick(wd_t), .xtal_tick(x_t));
   clock_source_select_and_distribution i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .SRC_FUSES(src_f), .STARTUP_FUSES(startup_f), .SWING_FUSE(swing), .SRC_TICK(src_t),
      .WDOG_TICK(wd_t), .XTAL32_TICK(x_t), .SLEEP_MODE(mode), .SLEEP_REQ(sreq),
      .WAKE_EVT(wake), .ASYNC_IRQ(irq), .TWO_WIRE_HIT(hit), .CORE_CLK_EN(core),
      .FLASH_CLK_EN(flash), .PERIPH_CLK_EN(per), .CONV_CLK_EN(conv), .ASYNC_CLK_EN(asy),
      .SRC_SEL(sel), .FULL_SWING(fsw), .RUNNING(run), .WAKE_OUT(wo));
   task automatic complete_run;
      $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [2:0] exp_src(input logic [3:0] f);
      if (f >= 4'ha) return SRC_CRYSTAL;
      if (f == 4'h9) return SRC_LOWFREQ;
      if (f >= 4'h5) return SRC_EXT_RC;
      if (f >= 4'h1) return SRC_INT_RC;
      return SRC_EXT_CLK;
   endfunction : exp_src
   task automatic do_reset(input logic [3:0] s, input logic [1:0] u, input logic w);
      @(negedge clk_sys);
      rst_n = 1'b0;
      src_f = s;
      startup_f = u;
      swing = w;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
   endtask : do_reset
   // Bounded wait; a hang ends the run with a counted mismatch
   task automatic wait_run(input int lim, output int n);
      n = 0;
      while (run !== 1'b1 && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= lim) begin
         miscompares++;
         complete_run();
      end
   endtask : wait_run
   task automatic decode_all;
      for (int f = 0; f < 16; f++) begin
         do_reset(f[3:0], 2'h0, f[0]);
         chk("source", {13'h0, exp_src(f[3:0])}, {13'h0, sel});
         chk("swing", {15'h0, ~f[0]}, {15'h0, fsw});
         src_f = ~f[3:0];
         swing = ~f[0];
         repeat (3) @(negedge clk_sys);
         chk("source held", {13'h0, exp_src(f[3:0])}, {13'h0, sel});
      end
   endtask : decode_all
   // Deep modes must take k source periods of 8 cycles before running again
   task automatic sleep_wake(input sleep_e m, input logic [3:0] en, input int how, input int k);
      int n;
      @(negedge clk_sys);
      mode = m;
      sreq = 1'b1;
      @(negedge clk_sys);
      sreq = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("sleep enables", {12'h0, en}, {12'h0, core, flash, per, conv});
      n = 0;
      while (asy !== 1'b1 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      chk("async pulse", 16'h1, {15'h0, asy});
      if (how == 0) wake = 1'b1;
      if (how == 1) irq = 1'b1;
      if (how == 2) hit = 1'b1;
      // Async sources need two sync stages before the sequencer leaves the run state
      repeat (2) @(negedge clk_sys);
      chk("wake out", {15'h0, how != 0}, {15'h0, wo});
      @(negedge clk_sys);
      {wake, irq, hit} = 3'h0;
      wait_run(20000, n);
      if (k == 0) chk("quick wake", 16'h1, {15'h0, n <= 4});
      else chk("start-up", 16'h1, {15'h0, n >= k * 8 - 24 && n <= k * 8 + 24});
      repeat (2) @(negedge clk_sys);
      chk("awake enables", 16'hf, {12'h0, core, flash, per, conv});
   endtask : sleep_wake
   initial begin
      int n;
      repeat (4) @(negedge clk_sys);
      chk("reset source", {13'h0, SRC_INT_RC}, {13'h0, sel});
      chk("reset running", 16'h0, {15'h0, run});
      decode_all();
      do_reset(4'he, 2'h2, 1'b0);
      wait_run(60, n);
      repeat (2) @(negedge clk_sys);
      chk("run enables", 16'hf, {12'h0, core, flash, per, conv});
      sleep_wake(SLP_IDLE, 4'h3, 0, 0);
      sleep_wake(SLP_ADC_NR, 4'h1, 0, 0);
      sleep_wake(SLP_PWR_DOWN, 4'h0, 0, 1024);
      sleep_wake(SLP_PWR_SAVE, 4'h0, 1, 1024);
      sleep_wake(SLP_STANDBY, 4'h0, 2, 1024);
      do_reset(4'h5, 2'h0, 1'b1);
      wait_run(60, n);
      sleep_wake(SLP_PWR_DOWN, 4'h0, 0, 18);
      complete_run();
   end
endmodule : clock_source_select_and_distribution_bench
